// [sili_pkg.sv]
// Constants and types for the sync/isochronous line interface.
// Assumes a 200 MHz system clock; register indices are small bus selects.
package sili_pkg;
  // Register selects
  localparam logic [2:0] SEL_RECEIVE_CONTROL_STATUS = 3'h0;
  localparam logic [2:0] SEL_RXDB  = 3'h1;
  localparam logic [2:0] SEL_PAR   = 3'h2;
  localparam logic [2:0] SEL_TRANSMIT_CONTROL_STATUS = 3'h3;
  localparam logic [2:0] SEL_TXDB  = 3'h4;
  // Receive control/status writable bits
  localparam int RC_STRIP = 8;
  localparam int RC_RXIE  = 6;
  localparam int RC_DTR   = 1;
  localparam int RC_SRCH  = 4;
  localparam int RC_DSIE  = 5;
  localparam int RC_RTS   = 2;
  localparam int RC_SECTX = 3;
  localparam logic [15:0] RC_WMASK = 16'h017E;
  // Parameter fields
  localparam int PA_MODE = 12;
  localparam int PA_LEN  = 10;
  localparam int PA_PEN  = 9;
  localparam int PA_EVEN = 8;
  localparam int PA_SYNC = 0;
  localparam logic [15:0] PA_WMASK = 16'h3FFF;
  // Transmit control/status fields
  localparam int TC_MDATA = 14;
  localparam int TC_SSCLK = 13;
  localparam int TC_MAINT = 11;
  localparam int TC_MCLR  = 8;
  localparam int TC_TXIE  = 6;
  localparam int TC_HALF  = 3;
  localparam int TC_BRK   = 0;
  localparam int TC_SEND  = 4;
  localparam int TC_DNAIE = 5;
  localparam logic [15:0] TC_WMASK = 16'h7879;
  // Synchronised pin vector layout
  localparam int IX_TXC   = 0;
  localparam int IX_RXC   = 1;
  localparam int IX_RXD   = 2;
  localparam int IX_DSR   = 3;
  localparam int IX_SECRX = 4;
  localparam int IX_CAR   = 5;
  localparam int IX_CTS   = 6;
  localparam int IX_RING  = 7;
  localparam int MDM_W    = 5;
  // Character framing
  localparam logic [3:0] MIN_LEN   = 4'h5;
  localparam logic [3:0] CHAR_MAX  = 4'h8;
  localparam logic [3:0] ISO_EXTRA = 4'h2;
  localparam logic [7:0] BUF_INIT  = 8'hFF;
  // Master clear pulse
  localparam int CLK_PERIOD_PS = 5000;
  localparam int MCLR_US       = 3;
  localparam int MCLR_CYC      = (MCLR_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int MCLR_W        = 10;
  typedef enum logic [1:0] {
    MODE_ISO = 2'b00, MODE_BAD = 2'b01, MODE_EXT = 2'b10, MODE_INT = 2'b11
  } sili_mode_t;
  typedef enum logic [1:0] {
    MAINT_NORMAL = 2'b00, MAINT_INT_LOOP = 2'b01, MAINT_EXT_LOOP = 2'b10, MAINT_TEST = 2'b11
  } sili_maint_t;
  typedef enum logic [1:0] {RX_HUNT = 2'b00, RX_DATA = 2'b01, RX_STOP = 2'b11} sili_rx_st_t;
  typedef enum logic {TX_IDLE = 1'b0, TX_SHIFT = 1'b1} sili_tx_st_t;
endpackage

// [sili_top.sv]
// Character-oriented sync/isochronous serial line interface, device side.
// Assumes bus strobes on sys_clk; modem clocks and pins are asynchronous.
`timescale 1ns/1ps
module sili_top #(
  parameter int CHAR_W = 8,
  parameter int DEPTH  = 2
)(
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  input  wire logic        bus_init,
  input  wire logic [2:0]  reg_sel,
  input  wire logic        reg_rd,
  input  wire logic        reg_wr,
  input  wire logic [15:0] reg_wdata,
  output logic      [15:0] reg_rdata,
  output logic             bus_reply,
  output logic             tx_load_ready,
  input  wire logic        modem_tx_clk,
  input  wire logic        modem_rx_clk,
  input  wire logic        serial_rx_in,
  input  wire logic [4:0]  modem_stat,
  output logic             serial_tx_out,
  output logic             rts_out,
  output logic             dtr_out,
  output logic             sec_tx_out,
  output logic             rx_irq_req,
  output logic             tx_irq_req,
  output logic             irq_vec_rx
);
  import sili_pkg::*;

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  if (CHAR_W != 8 || DEPTH < 2) begin : g_chk
    $error("sili_top: CHAR_W must be 8 and DEPTH at least 2");
  end

  // Pin synchronisers; stage 3 only feeds edge and change detection
  logic [7:0] pin_s1_r;
  logic [7:0] pin_s2_r;
  logic [7:0] pin_s3_r;
  wire  [7:0] pins_in = {modem_stat, serial_rx_in, modem_rx_clk, modem_tx_clk};

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_s1_r <= 8'h00;
      pin_s2_r <= 8'h00;
      pin_s3_r <= 8'h00;
    end else begin
      pin_s1_r <= pins_in;
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
    end
  end

  // Register strobes
  wire rd_receive_control_status = reg_rd & (reg_sel == SEL_RECEIVE_CONTROL_STATUS);
  wire rd_rxdb  = reg_rd & (reg_sel == SEL_RXDB);
  wire rd_transmit_control_status = reg_rd & (reg_sel == SEL_TRANSMIT_CONTROL_STATUS);
  wire wr_receive_control_status = reg_wr & (reg_sel == SEL_RECEIVE_CONTROL_STATUS);
  wire wr_par   = reg_wr & (reg_sel == SEL_PAR);
  wire wr_transmit_control_status = reg_wr & (reg_sel == SEL_TRANSMIT_CONTROL_STATUS);
  wire wr_txdb  = reg_wr & (reg_sel == SEL_TXDB);
  wire wr_mclr  = wr_transmit_control_status & reg_wdata[TC_MCLR];

  logic [MCLR_W-1:0] mclr_cnt_r;
  wire               clear_pulse = (mclr_cnt_r != '0);
  wire               clr = clear_pulse | bus_init;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) mclr_cnt_r <= '0;
    else if (wr_mclr) mclr_cnt_r <= MCLR_W'(MCLR_CYC);
    else if (clear_pulse) mclr_cnt_r <= mclr_cnt_r - 1'b1;
  end

  // Software control registers
  logic [15:0] rc_ctl_r;
  logic [15:0] par_r;
  logic [15:0] tc_r;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rc_ctl_r <= 16'h0000;
      par_r    <= 16'h0000;
      tc_r     <= 16'h0000;
    end else if (clr) begin
      rc_ctl_r <= 16'h0000;
      tc_r     <= 16'h0000;
    end else begin
      if (wr_receive_control_status) rc_ctl_r <= reg_wdata & RC_WMASK;
      if (wr_par) par_r <= reg_wdata & PA_WMASK;
      if (wr_transmit_control_status) tc_r <= reg_wdata & TC_WMASK;
    end
  end

  wire sili_mode_t  mode  = sili_mode_t'(par_r[PA_MODE +: 2]);
  wire sili_maint_t maint = sili_maint_t'(tc_r[TC_MAINT +: 2]);
  wire        iso    = ~mode[1];
  wire [3:0]  len    = MIN_LEN + {2'b00, par_r[PA_LEN +: 2]};
  wire        pen    = par_r[PA_PEN];
  wire        even   = par_r[PA_EVEN];
  wire [7:0]  sync_c = par_r[PA_SYNC +: 8];
  wire        send   = tc_r[TC_SEND];
  wire        loop   = (maint == MAINT_INT_LOOP) | (maint == MAINT_EXT_LOOP);
  wire [3:0]  nb     = len + {3'b000, pen};
  wire [7:0]  len_mask = BUF_INIT >> (CHAR_MAX - len);

  // Bit clocks and receive data source
  logic ss_d_r;
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) ss_d_r <= 1'b0;
    else ss_d_r <= tc_r[TC_SSCLK];
  end
  wire ss_rise = tc_r[TC_SSCLK] & ~ss_d_r;
  wire tbit = loop ? ss_rise : (pin_s2_r[IX_TXC] & ~pin_s3_r[IX_TXC]);
  wire rbit = loop ? ss_rise : (pin_s2_r[IX_RXC] & ~pin_s3_r[IX_RXC]);
  wire rx_din = loop ? tc_r[TC_MDATA] : pin_s2_r[IX_RXD];

  // Transmit buffer, two entries deep by default
  logic [CHAR_W-1:0] fifo_m [DEPTH];
  logic [PW-1:0]     wp_r;
  logic [PW-1:0]     rp_r;
  logic [PW:0]       fcnt_r;
  wire full  = (fcnt_r == (PW+1)'(DEPTH));
  wire empty = (fcnt_r == '0);
  wire push  = wr_txdb & ~full;
  wire tx_take;
  assign tx_load_ready = ~full;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < DEPTH; i++) fifo_m[i] <= BUF_INIT;
      wp_r   <= '0;
      rp_r   <= '0;
      fcnt_r <= '0;
    end else if (clr) begin
      for (int i = 0; i < DEPTH; i++) fifo_m[i] <= BUF_INIT;
      wp_r   <= '0;
      rp_r   <= '0;
      fcnt_r <= '0;
    end else begin
      if (push) begin
        fifo_m[wp_r] <= reg_wdata[CHAR_W-1:0];
        wp_r <= (wp_r == PW'(DEPTH - 1)) ? '0 : wp_r + 1'b1;
      end
      if (tx_take) rp_r <= (rp_r == PW'(DEPTH - 1)) ? '0 : rp_r + 1'b1;
      fcnt_r <= fcnt_r + (PW+1)'(push) - (PW+1)'(tx_take);
    end
  end

  // Transmitter framing
  sili_tx_st_t tx_st_r;
  logic [10:0] tx_sh_r;
  logic [3:0]  tx_cnt_r;
  logic        txo_r;
  logic        tx_done_r;
  logic        dna_r;

  wire        tx_end  = tbit & ((tx_st_r == TX_IDLE) | (tx_cnt_r == 4'h1));
  assign      tx_take = tx_end & send & ~empty;
  wire        tx_fill = tx_end & send & empty & ~iso & (tx_st_r == TX_SHIFT);
  wire        tx_go   = tx_take | tx_fill;
  wire [7:0]  tx_d    = (tx_take ? fifo_m[rp_r] : sync_c) & len_mask;
  wire        tx_p    = (^tx_d) ^ ~even;
  wire [8:0]  tx_body = {1'b0, tx_d} | ({8'h00, pen & tx_p} << len);
  wire [10:0] tx_iso  = ({2'b00, tx_body} | (11'h001 << nb)) << 1;
  wire [10:0] tx_fr   = iso ? tx_iso : {2'b00, tx_body};
  wire [3:0]  tx_flen = iso ? nb + ISO_EXTRA : nb;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_st_r  <= TX_IDLE;
      tx_sh_r  <= '0;
      tx_cnt_r <= '0;
      txo_r    <= 1'b1;
    end else if (clr) begin
      tx_st_r  <= TX_IDLE;
      tx_sh_r  <= '0;
      tx_cnt_r <= '0;
      txo_r    <= 1'b1;
    end else if (tx_go) begin
      tx_st_r  <= TX_SHIFT;
      txo_r    <= tx_fr[0];
      tx_sh_r  <= tx_fr >> 1;
      tx_cnt_r <= tx_flen;
    end else if (tx_end) begin
      tx_st_r  <= TX_IDLE;
      tx_cnt_r <= '0;
      txo_r    <= 1'b1;
    end else if (tbit) begin
      txo_r    <= tx_sh_r[0];
      tx_sh_r  <= tx_sh_r >> 1;
      tx_cnt_r <= tx_cnt_r - 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_done_r     <= 1'b1;
      dna_r         <= 1'b0;
      serial_tx_out <= 1'b1;
    end else begin
      tx_done_r     <= clr | tx_take | (tx_done_r & ~wr_txdb);
      dna_r         <= ~clr & (tx_fill | (dna_r & ~rd_transmit_control_status));
      serial_tx_out <= tc_r[TC_BRK] ? 1'b0 : txo_r;
    end
  end

  // Receiver
  sili_rx_st_t rx_st_r;
  logic [8:0]  rx_sh_r;
  logic [7:0]  rx_hr_r;
  logic [3:0]  rx_cnt_r;
  logic        rec_r;
  logic [7:0]  rxbuf_r;
  logic        done_r;
  logic        ovr_r;
  logic        frm_r;
  logic        per_r;

  wire        rx_en   = rc_ctl_r[RC_SRCH] & ~(tc_r[TC_HALF] & send);
  wire        rstep   = rbit & rx_en;
  wire [7:0]  hr_nx   = {rx_din, rx_hr_r[7:1]};
  wire        hunt_hit = (mode == MODE_INT) & ((hr_nx >> (CHAR_MAX - len)) == (sync_c & len_mask));
  wire        rx_start = (mode == MODE_INT) ? hunt_hit : ((mode == MODE_EXT) | ~rx_din);
  wire [8:0]  rx_cat  = rx_sh_r | ({8'h00, rx_din} << rx_cnt_r);
  wire        data_last = rstep & (rx_st_r == RX_DATA) & (rx_cnt_r == nb - 4'h1);
  wire        deliver = iso ? (rstep & (rx_st_r == RX_STOP)) : data_last;
  wire [8:0]  dv      = iso ? rx_sh_r : rx_cat;
  wire [3:0]  nb_cap  = (nb > CHAR_MAX) ? CHAR_MAX : nb;
  wire [7:0]  dv_field = dv[7:0] & (BUF_INIT >> (CHAR_MAX - nb_cap));
  wire        p_bad   = pen & ((^dv) ^ ~even);
  wire        f_bad   = iso & ~rx_din;
  wire        is_sync = (dv[7:0] & len_mask) == (sync_c & len_mask);
  wire        stripped = rc_ctl_r[RC_STRIP] & is_sync & ~p_bad & ~f_bad;
  wire        accept  = deliver & ~stripped;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_st_r  <= RX_HUNT;
      rx_sh_r  <= '0;
      rx_hr_r  <= '0;
      rx_cnt_r <= '0;
    end else if (clr | ~rx_en) begin
      rx_st_r  <= RX_HUNT;
      rx_sh_r  <= '0;
      rx_hr_r  <= '0;
      rx_cnt_r <= '0;
    end else if (rbit) begin
      unique case (rx_st_r)
        RX_HUNT: begin
          rx_hr_r <= hr_nx;
          if (rx_start) rx_st_r <= RX_DATA;
          rx_cnt_r <= '0;
          rx_sh_r  <= '0;
        end
        RX_DATA: begin
          rx_sh_r  <= rx_cat;
          rx_cnt_r <= rx_cnt_r + 1'b1;
          if (data_last) begin
            rx_cnt_r <= '0;
            if (iso) rx_st_r <= RX_STOP;
            else rx_sh_r <= '0;
          end
        end
        RX_STOP: begin
          rx_st_r <= RX_HUNT;
          rx_sh_r <= '0;
        end
        default: rx_st_r <= RX_HUNT;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rxbuf_r <= BUF_INIT;
      done_r  <= 1'b0;
      ovr_r   <= 1'b0;
      frm_r   <= 1'b0;
      per_r   <= 1'b0;
      rec_r   <= 1'b0;
    end else if (clr) begin
      rxbuf_r <= BUF_INIT;
      done_r  <= 1'b0;
      ovr_r   <= 1'b0;
      frm_r   <= 1'b0;
      per_r   <= 1'b0;
      rec_r   <= 1'b0;
    end else begin
      if (accept) rxbuf_r <= dv_field;
      done_r <= accept | (done_r & ~rd_rxdb);
      ovr_r  <= (accept & done_r & ~rd_rxdb) | (ovr_r & ~rd_rxdb);
      frm_r  <= (accept & f_bad) | (frm_r & ~rd_rxdb);
      per_r  <= pen & ((accept & p_bad) | (per_r & ~rd_rxdb));
      rec_r  <= rc_ctl_r[RC_SRCH] & (rec_r | (rstep & (rx_st_r == RX_HUNT) & hunt_hit));
    end
  end

  // Modem status change and interrupt requests
  logic dsch_r;
  wire  mdm_edge = |(pin_s2_r[IX_DSR +: MDM_W] ^ pin_s3_r[IX_DSR +: MDM_W]);
  wire  rx_req = (done_r & rc_ctl_r[RC_RXIE]) | (dsch_r & rc_ctl_r[RC_DSIE]);
  wire  tx_req = (tx_done_r & tc_r[TC_TXIE]) | (dna_r & tc_r[TC_DNAIE]);

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      dsch_r     <= 1'b0;
      rx_irq_req <= 1'b0;
      tx_irq_req <= 1'b0;
      irq_vec_rx <= 1'b0;
    end else begin
      dsch_r     <= ~clr & (mdm_edge | (dsch_r & ~rd_receive_control_status));
      rx_irq_req <= rx_req;
      tx_irq_req <= tx_req;
      irq_vec_rx <= rx_req;
    end
  end

  // Read data
  wire rec_act = (mode == MODE_INT) ? rec_r : rc_ctl_r[RC_SRCH];
  wire rx_err  = ovr_r | frm_r | per_r;
  wire [15:0] rd_rc = {dsch_r, pin_s2_r[IX_RING], pin_s2_r[IX_CTS], pin_s2_r[IX_CAR], rec_act,
                       pin_s2_r[IX_SECRX], pin_s2_r[IX_DSR], rc_ctl_r[RC_STRIP], done_r,
                       rc_ctl_r[RC_RXIE:RC_DTR], 1'b0};
  wire [15:0] rd_rx = {rx_err, ovr_r, frm_r, per_r, 4'h0, rxbuf_r};
  wire [15:0] rd_tc = {dna_r, tc_r[TC_MDATA:TC_MAINT], loop & rx_din, 1'b0, clear_pulse,
                       tx_done_r, tc_r[TC_TXIE:TC_HALF], 2'b00, tc_r[TC_BRK]};
  wire [15:0] rd_mux = (reg_sel == SEL_RECEIVE_CONTROL_STATUS) ? rd_rc :
                       (reg_sel == SEL_RXDB)  ? rd_rx :
                       (reg_sel == SEL_TRANSMIT_CONTROL_STATUS) ? rd_tc : 16'h0000;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 16'h0000;
      bus_reply <= 1'b0;
    end else begin
      if (reg_rd) reg_rdata <= rd_mux;
      bus_reply <= (reg_rd | reg_wr) & ~wr_mclr;
    end
  end

  assign rts_out    = rc_ctl_r[RC_RTS];
  assign dtr_out    = rc_ctl_r[RC_DTR];
  assign sec_tx_out = rc_ctl_r[RC_SECTX];

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  property p_err_sum;
    rd_rxdb |=> reg_rdata[15] == $past(ovr_r | frm_r | per_r);
  endproperty
  a_err_sum: assert property (p_err_sum) else $error("error summary wrong");
  property p_ovr;
    accept & done_r & ~rd_rxdb & ~clr |=> ovr_r;
  endproperty
  a_ovr: assert property (p_ovr) else $error("overrun not flagged");
  property p_frm;
    $rose(frm_r) |-> $past(iso);
  endproperty
  a_frm: assert property (p_frm) else $error("framing flag outside iso");
  property p_par_off;
    ~pen |=> ~per_r;
  endproperty
  a_par_off: assert property (p_par_off) else $error("parity flag with parity off");
  property p_init;
    clr |=> (rxbuf_r == BUF_INIT) && tx_done_r && !done_r;
  endproperty
  a_init: assert property (p_init) else $error("init state wrong");
  property p_mclr;
    wr_mclr |=> !bus_reply ##0 clear_pulse [*8];
  endproperty
  a_mclr: assert property (p_mclr) else $error("master clear pulse wrong");
  property p_break;
    tc_r[TC_BRK] && !clr |=> !serial_tx_out;
  endproperty
  a_break: assert property (p_break) else $error("break not low");
  property p_done;
    tx_take && !clr |=> tx_done_r;
  endproperty
  a_done: assert property (p_done) else $error("tx done not set");
  property p_dna;
    $rose(dna_r) |-> $past(!iso);
  endproperty
  a_dna: assert property (p_dna) else $error("fill flag in iso mode");
  property p_prio;
    rx_req && tx_req |=> irq_vec_rx && rx_irq_req && tx_irq_req;
  endproperty
  a_prio: assert property (p_prio) else $error("receiver not first");
  property p_half;
    tc_r[TC_HALF] && send |=> rx_st_r == RX_HUNT;
  endproperty
  a_half: assert property (p_half) else $error("receiver active in half duplex");
  property p_idle;
    tx_st_r == TX_IDLE |-> txo_r;
  endproperty
  a_idle: assert property (p_idle) else $error("idle not marking");
endmodule

// [sili_modem.sv]
// Behavioural synchronous modem facing the line side of sili_top.
// Tx clock runs only while tx_run is high; rx frames are sent by rx_send.
`timescale 1ns/1ps
module sili_modem (
  output logic       modem_tx_clk,
  output logic       modem_rx_clk,
  output logic       serial_rx_in,
  output logic [4:0] modem_stat,
  input  wire logic  serial_tx_out,
  input  wire logic  tx_run
);
  logic txq [$];
  initial begin
    modem_tx_clk = 1'b0;
    modem_rx_clk = 1'b0;
    serial_rx_in = 1'b1;
    modem_stat   = 5'h00;
  end
  // Sample each sent bit on the falling clock edge, 24 ns after the rise, shortly after the output settles
  always begin
    wait (tx_run);
    #24 modem_tx_clk = 1'b1;
    #24 txq.push_back(serial_tx_out);
    modem_tx_clk = 1'b0;
  end
  // Bits LSB first; line returns to mark, clock stands still between frames
  task automatic rx_send(input logic [11:0] f);
    for (int i = 0; i < 12; i++) begin
      serial_rx_in = f[i];
      #24 modem_rx_clk = 1'b1;
      #24 modem_rx_clk = 1'b0;
    end
    serial_rx_in = 1'b1;
  endtask
endmodule

// [tb_top.sv]
// Self-checking bench for sili_top with a behavioural modem on the line.
// Register bus strobes are driven 1 ns after the rising sys_clk edge.
`timescale 1ns/1ps
module tb_top;
  import sili_pkg::*;
  logic        sys_clk   = 1'b0;
  logic        reset_n   = 1'b0;
  logic        bus_init  = 1'b0;
  logic [2:0]  reg_sel   = 3'h0;
  logic        reg_rd    = 1'b0;
  logic        reg_wr    = 1'b0;
  logic [15:0] reg_wdata = 16'h0000;
  logic        tx_run    = 1'b0;
  logic [15:0] reg_rdata;
  logic        bus_reply, tx_load_ready, serial_tx_out, rts_out, dtr_out, sec_tx_out;
  logic        rx_irq_req, tx_irq_req, irq_vec_rx;
  logic        modem_tx_clk, modem_rx_clk, serial_rx_in;
  logic [4:0]  modem_stat;
  int          n_fail  = 0;
  int          checked = 0;
  int          cyc     = 0;

  sili_top dut (
    .sys_clk(sys_clk), .reset_n(reset_n), .bus_init(bus_init), .reg_sel(reg_sel),
    .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .bus_reply(bus_reply), .tx_load_ready(tx_load_ready), .modem_tx_clk(modem_tx_clk),
    .modem_rx_clk(modem_rx_clk), .serial_rx_in(serial_rx_in), .modem_stat(modem_stat),
    .serial_tx_out(serial_tx_out), .rts_out(rts_out), .dtr_out(dtr_out),
    .sec_tx_out(sec_tx_out), .rx_irq_req(rx_irq_req), .tx_irq_req(tx_irq_req),
    .irq_vec_rx(irq_vec_rx)
  );
  sili_modem modem (
    .modem_tx_clk(modem_tx_clk), .modem_rx_clk(modem_rx_clk), .serial_rx_in(serial_rx_in),
    .modem_stat(modem_stat), .serial_tx_out(serial_tx_out), .tx_run(tx_run)
  );

  always #2.5 sys_clk = ~sys_clk;

  task automatic conclude;
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      conclude();
    end
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t ns: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic wr(input logic [2:0] s, input logic [15:0] d);
    @(posedge sys_clk) #1;
    reg_sel   = s;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(posedge sys_clk) #1;
    reg_wr = 1'b0;
  endtask

  task automatic rd(input logic [2:0] s, output logic [15:0] v);
    @(posedge sys_clk) #1;
    reg_sel = s;
    reg_rd  = 1'b1;
    @(posedge sys_clk) #1;
    reg_rd = 1'b0;
    v      = reg_rdata;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  // Line frame: start, n data bits LSB first, optional parity, stop, then mark
  function automatic logic [11:0] frm(input logic [7:0] d, input int n, input logic pe,
                                      input logic ev, input logic bad, input logic stp);
    logic [11:0] f;
    logic [7:0]  m;
    int          k;
    m = d & (8'hFF >> (8 - n));
    f = 12'hFFE;
    for (int i = 0; i < n; i++) f[i + 1] = m[i];
    k = n + 1;
    if (pe) begin
      f[k] = ^m ^ ~ev ^ bad;
      k++;
    end
    f[k] = stp;
    return f;
  endfunction

  function automatic logic [7:0] grab(input int i);
    logic [7:0] b;
    for (int j = 0; j < 8; j++) b[j] = modem.txq[i + j];
    return b;
  endfunction

  task automatic t_regs;
    logic [15:0] v;
    logic [15:0] ev [6] = '{16'h0000, 16'h00FF, 16'h0000, 16'h0080, 16'h0000, 16'h0000};
    chk({15'h0000, serial_tx_out}, 16'h0001, "idle line");
    wr(SEL_PAR, 16'h3FFF);
    wr(SEL_TRANSMIT_CONTROL_STATUS, 16'h8400);
    wr(3'h5, 16'hFFFF);
    for (int s = 0; s < 6; s++) begin
      rd(3'(s), v);
      chk(v, ev[s], "reset value");
    end
    chk({15'h0000, bus_reply}, 16'h0001, "unmapped reply");
    $display("test regs finished");
  endtask

  task automatic t_tx;
    logic [15:0] v;
    int          i;
    wr(SEL_PAR, 16'h0F00);
    wr(SEL_TRANSMIT_CONTROL_STATUS, 16'h0040);
    idle(4);
    chk({15'h0000, tx_irq_req}, 16'h0001, "done request");
    wr(SEL_TXDB, 16'h0041);
    wr(SEL_TXDB, 16'h00C3);
    chk({15'h0000, tx_load_ready}, 16'h0000, "buffer full");
    rd(SEL_TRANSMIT_CONTROL_STATUS, v);
    chk(v & 16'h0080, 16'h0000, "done after load");
    chk({15'h0000, tx_irq_req}, 16'h0000, "request drop");
    modem.txq.delete();
    tx_run = 1'b1;
    wr(SEL_TRANSMIT_CONTROL_STATUS, 16'h0050);
    idle(400);
    tx_run = 1'b0;
    idle(20);
    i = 0;
    while (i < modem.txq.size() && modem.txq[i] !== 1'b0) i++;
    chk({6'h00, modem.txq[i + 10], modem.txq[i + 9], grab(i + 1)}, 16'h0241, "frame 1");
    chk({6'h00, modem.txq[i + 21], modem.txq[i + 20], grab(i + 12)}, 16'h02C3, "frame 2");
    rd(SEL_TRANSMIT_CONTROL_STATUS, v);
    chk(v & 16'h0080, 16'h0080, "done after send");
    chk({14'h0000, serial_tx_out, tx_load_ready}, 16'h0003, "paused mark");
    wr(SEL_TRANSMIT_CONTROL_STATUS, 16'h0000);
    $display("test tx finished");
  endtask

  task automatic t_rx;
    logic [15:0] v;
    wr(SEL_PAR, 16'h0F00);
    wr(SEL_RECEIVE_CONTROL_STATUS, 16'h0050);
    modem.rx_send(frm(8'h55, 8, 1'b1, 1'b1, 1'b0, 1'b1));
    idle(8);
    chk({14'h0000, rx_irq_req, irq_vec_rx}, 16'h0003, "rx request");
    rd(SEL_RXDB, v);
    chk(v, 16'h0055, "char 8 bit");
    rd(SEL_RECEIVE_CONTROL_STATUS, v);
    chk(v & 16'h0080, 16'h0000, "done cleared");
    modem.rx_send(frm(8'h12, 8, 1'b1, 1'b1, 1'b0, 1'b1));
    modem.rx_send(frm(8'h34, 8, 1'b1, 1'b1, 1'b0, 1'b0));
    idle(8);
    rd(SEL_RXDB, v);
    chk(v, 16'hE034, "overrun framing");
    rd(SEL_RXDB, v);
    chk(v, 16'h0034, "flags cleared");
    modem.rx_send(frm(8'h0F, 8, 1'b1, 1'b1, 1'b1, 1'b1));
    idle(8);
    rd(SEL_RXDB, v);
    chk(v, 16'h900F, "parity fault");
    wr(SEL_PAR, 16'h0200);
    modem.rx_send(frm(8'h11, 5, 1'b1, 1'b0, 1'b0, 1'b1));
    idle(8);
    rd(SEL_RXDB, v);
    chk(v, 16'h0031, "char 5 bit odd");
    wr(SEL_TRANSMIT_CONTROL_STATUS, 16'h0018);
    modem.rx_send(frm(8'h11, 5, 1'b1, 1'b0, 1'b0, 1'b1));
    idle(8);
    rd(SEL_RECEIVE_CONTROL_STATUS, v);
    chk(v & 16'h0080, 16'h0000, "half duplex");
    wr(SEL_TRANSMIT_CONTROL_STATUS, 16'h0000);
    wr(SEL_RECEIVE_CONTROL_STATUS, 16'h0000);
    $display("test rx finished");
  endtask

  task automatic t_brk;
    wr(SEL_TRANSMIT_CONTROL_STATUS, 16'h0001);
    idle(4);
    chk({15'h0000, serial_tx_out}, 16'h0000, "break space");
    wr(SEL_TRANSMIT_CONTROL_STATUS, 16'h0000);
    idle(4);
    chk({15'h0000, serial_tx_out}, 16'h0001, "break off");
    $display("test break finished");
  endtask

  task automatic t_modem;
    logic [15:0] v;
    wr(SEL_RECEIVE_CONTROL_STATUS, 16'h0020);
    modem.modem_stat = 5'h04;
    idle(8);
    chk({15'h0000, rx_irq_req}, 16'h0001, "modem request");
    rd(SEL_RECEIVE_CONTROL_STATUS, v);
    chk(v & 16'h9000, 16'h9000, "modem change");
    rd(SEL_RECEIVE_CONTROL_STATUS, v);
    idle(4);
    chk({v[15], 14'h0000, rx_irq_req}, 16'h0000, "change cleared");
    wr(SEL_RECEIVE_CONTROL_STATUS, 16'h0000);
    $display("test modem finished");
  endtask

  task automatic t_fill;
    logic [15:0] v;
    logic        f;
    f = 1'b0;
    wr(SEL_PAR, 16'h3C16);
    wr(SEL_TRANSMIT_CONTROL_STATUS, 16'h0030);
    wr(SEL_TXDB, 16'h005A);
    modem.txq.delete();
    tx_run = 1'b1;
    idle(400);
    tx_run = 1'b0;
    idle(20);
    chk({15'h0000, tx_irq_req}, 16'h0001, "fill request");
    rd(SEL_TRANSMIT_CONTROL_STATUS, v);
    chk(v & 16'h8000, 16'h8000, "fill flag");
    for (int i = 8; i + 8 < modem.txq.size(); i++) if (grab(i) === 8'h16) f = 1'b1;
    chk({15'h0000, f}, 16'h0001, "fill char");
    rd(SEL_TRANSMIT_CONTROL_STATUS, v);
    chk(v & 16'h8000, 16'h0000, "fill read clear");
    $display("test fill finished");
  endtask

  task automatic t_mclr;
    logic [15:0] v;
    wr(SEL_TRANSMIT_CONTROL_STATUS, 16'h0140);
    chk({15'h0000, bus_reply}, 16'h0000, "no reply");
    rd(SEL_TRANSMIT_CONTROL_STATUS, v);
    chk(v & 16'h0100, 16'h0100, "clear bit");
    idle(620);
    rd(SEL_TRANSMIT_CONTROL_STATUS, v);
    chk(v, 16'h0080, "after clear");
    rd(SEL_RXDB, v);
    chk(v, 16'h00FF, "rx buffer ones");
    $display("test master clear finished");
  endtask

  // Internal loop: step an isochronous 5-bit frame in through the maintenance bits
  task automatic t_loop;
    logic [15:0] v;
    logic [6:0]  f;
    f = 7'h62;
    wr(SEL_PAR, 16'h0000);
    wr(SEL_RECEIVE_CONTROL_STATUS, 16'h001E);
    chk({13'h0000, sec_tx_out, rts_out, dtr_out}, 16'h0007, "modem lines");
    for (int b = 0; b < 7; b++) begin
      wr(SEL_TRANSMIT_CONTROL_STATUS, {1'b0, f[b], 1'b1, 2'b01, 11'h000});
      wr(SEL_TRANSMIT_CONTROL_STATUS, {1'b0, f[b], 1'b0, 2'b01, 11'h000});
    end
    rd(SEL_TRANSMIT_CONTROL_STATUS, v);
    chk(v & 16'h4400, 16'h4400, "loop input");
    rd(SEL_RXDB, v);
    chk(v, 16'h0011, "loop char");
    wr(SEL_TRANSMIT_CONTROL_STATUS, 16'h0000);
    wr(SEL_RECEIVE_CONTROL_STATUS, 16'h0000);
    $display("test loop finished");
  endtask

  initial begin
    repeat (16) @(posedge sys_clk);
    #1 reset_n = 1'b1;
    t_regs();
    t_tx();
    t_rx();
    t_brk();
    t_modem();
    t_fill();
    t_mclr();
    t_loop();
    conclude();
  end
endmodule
